// file: testbench/agt_host.sv
`timescale 1ns/100ps
`default_nettype none
module agt_host (
   input  wire logic        pclk,    // bus clock
   input  wire logic        pready,  // slave ready
   input  wire logic        pslverr, // slave error
   input  wire logic [31:0] prdata,  // read data
   output logic             psel,    // select
   output logic             penable, // access phase
   output logic             pwrite,  // direction
   output logic      [7:0]  paddr,   // byte address
   output logic      [31:0] pwdata,  // write data
   output logic      [3:0]  pstrb,   // byte strobes
   output logic             lost     // answer never came
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hF;
      lost = 1'b0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 32);
      lost <= lost | (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released address and data lines show garbage, not the last value
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

// file: testbench/agt_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
module agt_regs_test;
   import agt_pkg::*;
   logic        pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, lost, e;
   logic        tx_common_mode_select, tx_mute, tx_attenuation, rx_mute, cal_busy, irq;
   logic [1:0]  rx_attenuation;
   logic [7:0]  paddr, g;
   logic [3:0]  pstrb;
   logic [31:0] pwdata, prdata, q;
   logic [11:0] trim_step_active;
   int          fails, cmp_count, busy_cyc;
   // address, write data, expected readback
   logic [23:0] rows [10] = '{24'h548080, 24'h544040, 24'h541010, 24'h540404,
      24'h540101, 24'h540202, 24'h542800, 24'h30C000, 24'h303F3F, 24'h2C7F3F};
   agt_regs u_agt_regs (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_common_mode_select(tx_common_mode_select), .tx_mute(tx_mute),
      .tx_attenuation(tx_attenuation), .rx_mute(rx_mute), .rx_attenuation(rx_attenuation),
      .trim_step_active(trim_step_active), .cal_busy(cal_busy), .irq(irq));
   agt_host u_agt_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .lost(lost));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) if (cal_busy === 1'b1) busy_cyc <= busy_cyc + 1;
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      u_agt_host.xfer(1'b1, a, {24'h0, d}, 4'hF, q, e);
   endtask
   task rd(input logic [7:0] a);
      u_agt_host.xfer(1'b0, a, 32'h0, 4'hF, q, e);
   endtask
   task report_and_stop;
      if (fails == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task cal_run(input logic [7:0] t1, input logic [7:0] t2);
      int k, lo;
      logic [11:0] v, h;
      v = {t1[5:0], t2[5:0]};
      h = 12'h000;
      for (k = 0; k < 12; k++) if (v[k]) h = 12'h001 << k;
      lo = $countones(v) * STEP_CYC + 1;
      busy_cyc = 0;
      wr(ADDR_TRIM2, t2);
      wr(ADDR_TRIM1, t1 | 8'h80);
      if (v != 12'h000) begin
         wr(ADDR_TRIM1, 8'h00);
         rd(ADDR_TRIM1);
         chk("trim1 running", q, {24'h0, t1 | 8'h80});
         chk("busy", cal_busy, 32'h1);
         chk("first step", trim_step_active, h);
      end
      repeat (2) @(posedge pclk);
      for (k = 0; k < 4000 && cal_busy !== 1'b0; k++) @(posedge pclk);
      chk("cal length", 32'(busy_cyc >= lo && busy_cyc <= lo + 1), 32'h1);
      rd(ADDR_TRIM1);
      chk("trim1 done", q, 32'h0);
      rd(ADDR_TRIM2);
      chk("trim2 done", q, 32'h0);
      chk("done irq", irq, 32'h1);
      rd(ADDR_IRQ_ST);
      chk("done status", q, 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      report_and_stop;
   end
   initial begin
      fails = 0;
      cmp_count = 0;
      busy_cyc = 0;
      g = 8'h00;
      presetn = 1'b0;
      pce = 1'b1;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         rd(rows[i][23:16]);
         chk("reset value", q, 32'h0);
      end
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16]);
         chk("readback", q, {24'h0, rows[i][7:0]});
         if (rows[i][23:16] == ADDR_GAIN) g = rows[i][7:0];
         chk("cm select", tx_common_mode_select, g[7]);
         chk("tx mute", tx_mute, g[6]);
         chk("tx atten", tx_attenuation, g[4]);
         chk("rx mute", rx_mute, g[2]);
         chk("rx atten", rx_attenuation, g[1:0]);
      end
      // clock enable low freezes a transfer in flight
      pce <= 1'b0;
      fork
         wr(ADDR_GAIN, 8'h10);
         begin
            repeat (4) @(posedge pclk);
            chk("frozen ready", pready, 32'h0);
            pce <= 1'b1;
         end
      join
      rd(ADDR_GAIN);
      chk("thawed write", q, 32'h10);
      chk("thawed atten", tx_attenuation, 32'h1);
      // a write without its low byte strobe is dropped
      u_agt_host.xfer(1'b1, ADDR_GAIN, 32'h0000_0080, 4'h0, q, e);
      rd(ADDR_GAIN);
      chk("no strobe write", q, 32'h10);
      rd(8'h00);
      chk("unmapped err", {31'h0, e}, 32'h1);
      chk("unmapped data", q, 32'h0);
      wr(ADDR_IRQ_MSK, 8'h03);
      wr(ADDR_GAIN, 8'h02);
      // deliberate reserved receive code
      wr(ADDR_GAIN, 8'hC7);
      rd(ADDR_GAIN);
      chk("rx code kept", q, 32'hC6);
      chk("rx atten kept", rx_attenuation, 32'h2);
      chk("code irq", irq, 32'h1);
      rd(ADDR_IRQ_ST);
      chk("code status", q, 32'h2);
      rd(ADDR_IRQ_ST);
      chk("status cleared", q, 32'h0);
      chk("irq cleared", irq, 32'h0);
      wr(ADDR_IRQ_MSK, 8'h00);
      wr(ADDR_GAIN, 8'hFF);
      rd(ADDR_IRQ_ST);
      chk("masked irq", irq, 32'h0);
      chk("masked status", q, 32'h2);
      wr(ADDR_IRQ_MSK, 8'h03);
      cal_run(8'h3F, 8'h38);
      cal_run(8'h00, 8'h07);
      cal_run(8'h00, 8'h00);
      // reset in the middle of a run
      wr(ADDR_GAIN, 8'hD6);
      wr(ADDR_TRIM2, 8'h01);
      wr(ADDR_TRIM1, 8'h80);
      repeat (5) @(posedge pclk);
      chk("busy before reset", cal_busy, 32'h1);
      presetn <= 1'b0;
      @(posedge pclk);
      chk("reset outputs", 32'({tx_common_mode_select, tx_mute, tx_attenuation, rx_mute,
         rx_attenuation, irq, pready, pslverr}), 32'h0);
      chk("reset step", {20'h0, trim_step_active}, 32'h0);
      chk("reset busy", cal_busy, 32'h0);
      chk("reset data", prdata, 32'h0);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_TRIM1);
      chk("trim1 after reset", q, 32'h0);
      rd(ADDR_GAIN);
      chk("gain after reset", q, 32'h0);
      chk("bus answered", lost, 32'h0);
      report_and_stop;
   end
endmodule
`default_nettype wire

// file: verilog/agt_pkg.sv
// Behaviour
// - tx common-mode bit 7: 0 internal 1.5 V reference, 1 external pin.
// - tx mute bit 6: 0 passes transmit signal, 1 silences it.
// - tx attenuation bit 4: 0 none, 1 a -3 dB step.
// - rx mute bit 2: 0 passes receive signal, 1 silences it.
// - rx attenuation 00 none, 01 -3 dB, 10 -6 dB; 11 never used.
// - writing 1 to bit 7 starts calibration; reads 1 until done.
// - first trim bits 5..0 enable six calibrations, read 1 until done.
// - second trim bits 5..3 enable leakage and monitor calibrations.
// - second trim bits 2 and 1 enable audio dac/adc offset trims.
// - second trim bit 0 enables longitudinal balance trim, reads 0 after.
`default_nettype none
package agt_pkg;
   localparam int CLK_MHZ = 25;
   localparam int STEP_US = 10;
   localparam int STEP_CYC = STEP_US * CLK_MHZ;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYC - 1);
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_TRIM1 = 8'h0B;
   localparam logic [7:0] IDX_TRIM2 = 8'h0C;
   localparam logic [7:0] IDX_GAIN = 8'h15;
   localparam logic [7:0] IDX_IRQ_ST = 8'h16;
   localparam logic [7:0] IDX_IRQ_MSK = 8'h17;
   localparam logic [7:0] ADDR_TRIM1 = 8'(IDX_TRIM1 * 4);
   localparam logic [7:0] ADDR_TRIM2 = 8'(IDX_TRIM2 * 4);
   localparam logic [7:0] ADDR_GAIN = 8'(IDX_GAIN * 4);
   localparam logic [7:0] ADDR_IRQ_ST = 8'(IDX_IRQ_ST * 4);
   localparam logic [7:0] ADDR_IRQ_MSK = 8'(IDX_IRQ_MSK * 4);
   // field positions
   localparam int GAIN_CMSEL = 7;
   localparam int GAIN_TXMUTE = 6;
   localparam int GAIN_TXATT = 4;
   localparam int GAIN_RXMUTE = 2;
   localparam int TRIM1_START = 7;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_BADCODE = 1;
   localparam logic [1:0] RX_ATT_RSVD = 2'h3;
   // writable bit masks
   localparam logic [7:0] GAIN_MASK = 8'hD7;
   localparam logic [7:0] TRIM1_MASK = 8'hBF;
   localparam logic [7:0] TRIM2_MASK = 8'h3F;
   localparam logic [1:0] IRQ_MASK = 2'h3;
   // values after reset
   localparam logic [7:0] GAIN_RST = 8'h00;
   localparam logic [7:0] TRIM1_RST = 8'h00;
   localparam logic [7:0] TRIM2_RST = 8'h00;
   localparam logic [1:0] IRQ_RST = 2'h0;
   typedef enum logic [1:0] {
      AGT_IDLE = 2'b01,
      AGT_RUN  = 2'b10
   } agt_state_t;
endpackage
`default_nettype wire

// file: verilog/agt_regs.sv
`timescale 1ns/100ps
`default_nettype none
module agt_regs (
   input  wire logic        pclk,                  // bus clock
   input  wire logic        presetn,               // async reset, low
   input  wire logic        pce,                   // clock enable
   input  wire logic        psel,                  // apb select
   input  wire logic        penable,               // apb access phase
   input  wire logic        pwrite,                // apb direction
   input  wire logic [7:0]  paddr,                 // apb byte address
   input  wire logic [31:0] pwdata,                // apb write data
   input  wire logic [3:0]  pstrb,                 // apb byte strobes
   output logic      [31:0] prdata,                // apb read data
   output logic             pready,                // apb ready
   output logic             pslverr,               // unmapped address
   output logic             tx_common_mode_select, // 1 external pin
   output logic             tx_mute,               // transmit muted
   output logic             tx_attenuation,        // -3 dB step
   output logic             rx_mute,               // receive muted
   output logic      [1:0]  rx_attenuation,        // receive step
   output logic      [11:0] trim_step_active,      // running step
   output logic             cal_busy,              // sequence running
   output logic             irq                    // level interrupt
);
   import agt_pkg::*;

   ////////////////////////////////////////////////////////////////////
   logic [7:0]       gain_r, gain_nxt;
   logic [7:0]       t1_r, t1_nxt;
   logic [7:0]       t2_r, t2_nxt;
   logic [1:0]       st_r, st_nxt;
   logic [1:0]       msk_r, msk_nxt;
   logic [31:0]      prdata_r, prdata_nxt;
   logic             pready_r, pready_nxt;
   logic             pslverr_r, pslverr_nxt;
   logic [11:0]      act_r, act_nxt;
   logic             busy_r, busy_nxt;
   logic             irq_r, irq_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   agt_state_t       state_r, state_nxt;
   logic             acc, xfer, wr, hit;
   logic             s_t1, s_t2, s_gain, s_st, s_msk;
   logic [11:0]      pend, pend_nxt, first, first_nxt;
   logic             ev_done, ev_bad;
   logic [7:0]       gw;

   assign acc  = psel & penable & ~pready_r;
   assign xfer = psel & penable & pready_r;
   assign wr   = xfer & pwrite & pstrb[0];
   assign s_t1   = (paddr == ADDR_TRIM1);
   assign s_t2   = (paddr == ADDR_TRIM2);
   assign s_gain = (paddr == ADDR_GAIN);
   assign s_st   = (paddr == ADDR_IRQ_ST);
   assign s_msk  = (paddr == ADDR_IRQ_MSK);
   assign hit  = s_t1 | s_t2 | s_gain | s_st | s_msk;
   assign pend = {t1_r[5:0], t2_r[5:0]};
   assign pend_nxt = {t1_nxt[5:0], t2_nxt[5:0]};

   // steps run from the highest enable bit downward
   genvar gi;
   generate
      for (gi = 0; gi < 12; gi++) begin : g_first
         assign first[gi]     = pend[gi] & ~|(pend >> (gi + 1));
         assign first_nxt[gi] = pend_nxt[gi] & ~|(pend_nxt >> (gi + 1));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, data sampled with the access phase
   always_comb begin
      pready_nxt  = acc;
      pslverr_nxt = acc & ~hit;
      prdata_nxt  = prdata_r;
      if (acc) begin
         prdata_nxt = 32'h0000_0000;
         if (pwrite) begin
            prdata_nxt = prdata_r;
         end else if (s_t1) begin
            prdata_nxt[7:0] = t1_r;
         end else if (s_t2) begin
            prdata_nxt[7:0] = t2_r;
         end else if (s_gain) begin
            prdata_nxt[7:0] = gain_r;
         end else if (s_st) begin
            prdata_nxt[1:0] = st_r;
         end else if (s_msk) begin
            prdata_nxt[1:0] = msk_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // audio path settings
   always_comb begin
      gw       = pwdata[7:0] & GAIN_MASK;
      gain_nxt = gain_r;
      ev_bad   = 1'b0;
      if (wr && s_gain) begin
         gain_nxt = gw;
         if (gw[1:0] == RX_ATT_RSVD) begin
            gain_nxt[1:0] = gain_r[1:0];
            ev_bad        = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // calibration sequencer
   always_comb begin
      t1_nxt    = t1_r;
      t2_nxt    = t2_r;
      cnt_nxt   = cnt_r;
      state_nxt = state_r;
      ev_done   = 1'b0;
      case (state_r)
         AGT_IDLE: begin
            cnt_nxt = '0;
            if (wr && s_t1) begin
               t1_nxt = pwdata[7:0] & TRIM1_MASK;
               if (t1_nxt[TRIM1_START]) begin
                  state_nxt = AGT_RUN;
               end
            end
            if (wr && s_t2) begin
               t2_nxt = pwdata[7:0] & TRIM2_MASK;
            end
         end
         AGT_RUN: begin
            // trim writes are dropped here, so only reset can abort a run
            if (pend == 12'h000) begin
               t1_nxt[TRIM1_START] = 1'b0;
               state_nxt    = AGT_IDLE;
               ev_done      = 1'b1;
            end else if (cnt_r == STEP_LAST) begin
               cnt_nxt = '0;
               t1_nxt[5:0] = t1_r[5:0] & ~first[11:6];
               t2_nxt[5:0] = t2_r[5:0] & ~first[5:0];
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         default: begin
            state_nxt = AGT_IDLE;
         end
      endcase
   end

   // busy and the step display follow the state being entered
   assign busy_nxt = (state_nxt == AGT_RUN);
   assign act_nxt  = busy_nxt ? first_nxt : 12'h000;

   ////////////////////////////////////////////////////////////////////
   // interrupt: sticky status, read clears only what was returned
   always_comb begin
      msk_nxt = msk_r;
      st_nxt  = st_r;
      if (wr && s_msk) begin
         msk_nxt = pwdata[1:0] & IRQ_MASK;
      end
      if (xfer && !pwrite && s_st) begin
         st_nxt = st_r & ~prdata_r[1:0];
      end
      // a new event in the clearing cycle wins
      st_nxt[IRQ_DONE]    = st_nxt[IRQ_DONE] | ev_done;
      st_nxt[IRQ_BADCODE] = st_nxt[IRQ_BADCODE] | ev_bad;
      irq_nxt = |(st_nxt & msk_nxt);
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gain_r    <= GAIN_RST;
         t1_r      <= TRIM1_RST;
         t2_r      <= TRIM2_RST;
         st_r      <= IRQ_RST;
         msk_r     <= IRQ_RST;
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         act_r     <= 12'h000;
         busy_r    <= 1'b0;
         irq_r     <= 1'b0;
         cnt_r     <= '0;
         state_r   <= AGT_IDLE;
      end else if (pce) begin
         gain_r    <= gain_nxt;
         t1_r      <= t1_nxt;
         t2_r      <= t2_nxt;
         st_r      <= st_nxt;
         msk_r     <= msk_nxt;
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         act_r     <= act_nxt;
         busy_r    <= busy_nxt;
         irq_r     <= irq_nxt;
         cnt_r     <= cnt_nxt;
         state_r   <= state_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign tx_common_mode_select = gain_r[GAIN_CMSEL];
   assign tx_mute          = gain_r[GAIN_TXMUTE];
   assign tx_attenuation   = gain_r[GAIN_TXATT];
   assign rx_mute          = gain_r[GAIN_RXMUTE];
   assign rx_attenuation   = gain_r[1:0];
   assign trim_step_active = act_r;
   assign cal_busy         = busy_r;
   assign irq              = irq_r;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // audio path settings follow the bus write, except a reserved rx code, which is refused
   chk_tx_cm_write: assert property (
      pce && wr && s_gain |=> tx_common_mode_select == $past(pwdata[7]))
      else $error("common-mode select not taken from write");

   chk_tx_mute_write: assert property (
      pce && wr && s_gain |=> tx_mute == $past(pwdata[6]))
      else $error("tx mute not taken from write");

   chk_tx_att_write: assert property (
      pce && wr && s_gain |=> tx_attenuation == $past(pwdata[4]))
      else $error("tx attenuation not taken from write");

   chk_rx_mute_write: assert property (
      pce && wr && s_gain |=> rx_mute == $past(pwdata[2]))
      else $error("rx mute not taken from write");

   chk_rx_code_legal: assert property (
      rx_attenuation != RX_ATT_RSVD)
      else $error("reserved rx attenuation code applied");

   chk_bad_code_kept: assert property (
      pce && wr && s_gain && pwdata[1:0] == RX_ATT_RSVD
      |=> st_r[IRQ_BADCODE] && rx_attenuation == $past(rx_attenuation))
      else $error("reserved receive code not refused");

   // calibration sequencer
   chk_cal_start_busy: assert property (
      pce && wr && s_t1 && pwdata[7] && state_r == AGT_IDLE
      |=> t1_r[TRIM1_START] && cal_busy)
      else $error("calibration start not seen");

   chk_cal_end_clear: assert property (
      $fell(t1_r[TRIM1_START]) |-> pend == 12'h000 && $past(cal_busy))
      else $error("start bit fell with steps pending");

   chk_done_status: assert property (
      $fell(cal_busy) |-> st_r[IRQ_DONE])
      else $error("calibration end left no status");

   chk_step_hold: assert property (
      pce && state_r == AGT_RUN && cnt_r != STEP_LAST |=> pend == $past(pend))
      else $error("enable bit changed mid step");

   chk_step_first: assert property (
      cal_busy |-> (pend & ~(trim_step_active - 12'h001)) == trim_step_active)
      else $error("step not the highest pending enable");

   chk_step_length: assert property (
      pend != $past(pend) && $past(state_r) == AGT_RUN
      |-> $past(cnt_r) == STEP_LAST && $past(pce))
      else $error("step finished at wrong count");

   chk_idle_quiet: assert property (
      state_r == AGT_IDLE |-> !cal_busy && trim_step_active == 12'h000)
      else $error("step shown while idle");

   // bus and interrupt
   chk_reserved_zero: assert property (
      gain_r[5] == 1'b0 && gain_r[3] == 1'b0 && t1_r[6] == 1'b0
      && t2_r[7:6] == 2'b00)
      else $error("reserved bit set");

   chk_read_upper: assert property (
      pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read data not zero");

   chk_pready_pulse: assert property (
      pce && pready |=> !pready)
      else $error("ready held more than one cycle");

   chk_unmapped_err: assert property (
      pce && acc && !hit |=> pready && pslverr)
      else $error("unmapped access without error");

   chk_irq_level: assert property (
      irq == |(st_r & msk_r))
      else $error("interrupt does not follow status and mask");

   cov_full_cal: cover property ($fell(cal_busy));
   cov_bad_code: cover property (st_r[IRQ_BADCODE]);
   cov_irq_raise: cover property ($rose(irq));
   cov_unmapped: cover property (pready && pslverr);
   cov_frozen_access: cover property (!pce && psel && penable);
endmodule
`default_nettype wire
